// file: rtl/gpop_port.sv
// ports b, c and d with register file and port d alternate-function overrides
// assumes pad inputs are asynchronous and peripherals share clk
`timescale 1ns/1ps
`include "gpop_params.svh"
module gpop_port
	import gpop_pkg::*;
#(
	// port geometry
	parameter int PORT_W      = 8,
	parameter int SYNC_STAGES = 2
)
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// register port
	input  wire logic [`GPOP_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output logic      [7:0]              reg_rdata,
	// pads
	input  wire logic [7:0]              pad_b_in,
	input  wire logic [7:0]              pad_c_in,
	input  wire logic [7:0]              pad_d_in,
	output logic      [7:0]              pad_b_out,
	output logic      [7:0]              pad_b_oe,
	output logic      [7:0]              pad_b_pullup,
	output logic      [7:0]              pad_c_out,
	output logic      [7:0]              pad_c_oe,
	output logic      [7:0]              pad_c_pullup,
	output logic      [7:0]              pad_d_out,
	output logic      [7:0]              pad_d_oe,
	output logic      [7:0]              pad_d_pullup,
	output logic      [7:0]              pad_d_input_en,
	// serial unit
	input  wire logic                    transmitter_enable,
	input  wire logic                    receiver_enable,
	input  wire logic                    serial_tx_data,
	input  wire logic                    serial_sync_mode_select,
	input  wire logic                    serial_sync_clock_out,
	output logic                         serial_rx_data,
	output logic                         serial_sync_clock_in,
	// timers
	input  wire logic                    timer0_compare_a_enable,
	input  wire logic                    timer0_compare_out_a,
	input  wire logic                    timer0_compare_b_enable,
	input  wire logic                    timer0_compare_out_b,
	input  wire logic                    timer2_compare_b_enable,
	input  wire logic                    timer2_compare_out_b,
	output logic                         timer0_count_input,
	output logic                         timer1_count_input,
	// interrupt controller
	input  wire logic                    ext_irq_zero_enable,
	input  wire logic                    ext_irq_one_enable,
	input  wire logic [7:0]              pin_change_mask_d,
	input  wire logic                    pin_change_group2_enable,
	output logic                         ext_irq_zero,
	output logic                         ext_irq_one,
	output logic      [7:0]              pin_change_src_d
);
	// register file state
	gpop_byte_t b_dir_reg;
	gpop_byte_t b_dir_next;
	gpop_byte_t b_lat_reg;
	gpop_byte_t b_lat_next;
	gpop_byte_t c_dir_reg;
	gpop_byte_t c_dir_next;
	gpop_byte_t c_lat_reg;
	gpop_byte_t c_lat_next;
	gpop_byte_t d_dir_reg;
	gpop_byte_t d_dir_next;
	gpop_byte_t d_lat_reg;
	gpop_byte_t d_lat_next;
	gpop_byte_t ctrl_reg;
	gpop_byte_t ctrl_next;
	gpop_byte_t rdata_reg;
	gpop_byte_t rdata_next;
	// pad synchronisers
	gpop_byte_t b_s1_reg;
	gpop_byte_t b_s2_reg;
	gpop_byte_t c_s1_reg;
	gpop_byte_t c_s2_reg;
	gpop_byte_t d_s1_reg;
	gpop_byte_t d_s2_reg;
	// port d overrides
	gpop_byte_t d_pu_oe;
	gpop_byte_t d_pu_ov;
	gpop_byte_t d_dd_oe;
	gpop_byte_t d_dd_ov;
	gpop_byte_t d_pv_oe;
	gpop_byte_t d_pv_ov;
	gpop_byte_t d_die_oe;
	logic       pullup_off;

	// register map and override table are written for eight-pin ports
	if (PORT_W != 8) begin : g_chk_width
		$error("gpop_port: PORT_W must be 8");
	end
	// only the two-stage pad synchroniser is built
	if (SYNC_STAGES != 2) begin : g_chk_sync
		$error("gpop_port: SYNC_STAGES must be 2");
	end

	// one gate shared by every port pull-up
	assign pullup_off = ctrl_reg[`GPOP_CTRL_PUD_BIT];

	// pad synchronisers; pin-sense reads see the second stage only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			b_s1_reg <= `GPOP_RESET_VALUE;
			b_s2_reg <= `GPOP_RESET_VALUE;
			c_s1_reg <= `GPOP_RESET_VALUE;
			c_s2_reg <= `GPOP_RESET_VALUE;
			d_s1_reg <= `GPOP_RESET_VALUE;
			d_s2_reg <= `GPOP_RESET_VALUE;
		end else begin
			b_s1_reg <= pad_b_in;
			b_s2_reg <= b_s1_reg;
			c_s1_reg <= pad_c_in;
			c_s2_reg <= c_s1_reg;
			d_s1_reg <= pad_d_in;
			d_s2_reg <= d_s1_reg;
		end
	end

	// write decode; a pin-sense write toggles, so software flips a pin
	// in one store instead of a read-modify-write
	always_comb begin
		b_dir_next = b_dir_reg;
		b_lat_next = b_lat_reg;
		c_dir_next = c_dir_reg;
		c_lat_next = c_lat_reg;
		d_dir_next = d_dir_reg;
		d_lat_next = d_lat_reg;
		ctrl_next  = ctrl_reg;
		if (reg_write) begin
			if (reg_addr == `GPOP_OFF_B_PIN) begin
				b_lat_next = b_lat_reg ^ reg_wdata;
			end else if (reg_addr == `GPOP_OFF_B_DIR) begin
				b_dir_next = reg_wdata;
			end else if (reg_addr == `GPOP_OFF_B_LAT) begin
				b_lat_next = reg_wdata;
			end else if (reg_addr == `GPOP_OFF_C_PIN) begin
				c_lat_next = (c_lat_reg ^ reg_wdata) & `GPOP_PORT_C_MASK;
			end else if (reg_addr == `GPOP_OFF_C_DIR) begin
				c_dir_next = reg_wdata & `GPOP_PORT_C_MASK;
			end else if (reg_addr == `GPOP_OFF_C_LAT) begin
				c_lat_next = reg_wdata & `GPOP_PORT_C_MASK;
			end else if (reg_addr == `GPOP_OFF_D_PIN) begin
				d_lat_next = d_lat_reg ^ reg_wdata;
			end else if (reg_addr == `GPOP_OFF_D_DIR) begin
				d_dir_next = reg_wdata;
			end else if (reg_addr == `GPOP_OFF_D_LAT) begin
				d_lat_next = reg_wdata;
			end else if (reg_addr == `GPOP_OFF_CTRL) begin
				ctrl_next = reg_wdata & `GPOP_CTRL_MASK;
			end
		end
	end

	// read decode; unmapped offsets read zero
	always_comb begin
		rdata_next = 8'h00;
		if (reg_read) begin
			if (reg_addr == `GPOP_OFF_B_PIN) begin
				rdata_next = b_s2_reg;
			end else if (reg_addr == `GPOP_OFF_B_DIR) begin
				rdata_next = b_dir_reg;
			end else if (reg_addr == `GPOP_OFF_B_LAT) begin
				rdata_next = b_lat_reg;
			end else if (reg_addr == `GPOP_OFF_C_PIN) begin
				rdata_next = c_s2_reg & `GPOP_PORT_C_MASK;
			end else if (reg_addr == `GPOP_OFF_C_DIR) begin
				rdata_next = c_dir_reg;
			end else if (reg_addr == `GPOP_OFF_C_LAT) begin
				rdata_next = c_lat_reg;
			end else if (reg_addr == `GPOP_OFF_D_PIN) begin
				rdata_next = d_s2_reg;
			end else if (reg_addr == `GPOP_OFF_D_DIR) begin
				rdata_next = d_dir_reg;
			end else if (reg_addr == `GPOP_OFF_D_LAT) begin
				rdata_next = d_lat_reg;
			end else if (reg_addr == `GPOP_OFF_CTRL) begin
				rdata_next = ctrl_reg;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			b_dir_reg <= `GPOP_RESET_VALUE;
			b_lat_reg <= `GPOP_RESET_VALUE;
			c_dir_reg <= `GPOP_RESET_VALUE;
			c_lat_reg <= `GPOP_RESET_VALUE;
			d_dir_reg <= `GPOP_RESET_VALUE;
			d_lat_reg <= `GPOP_RESET_VALUE;
			ctrl_reg  <= `GPOP_RESET_VALUE;
		end else begin
			b_dir_reg <= b_dir_next;
			b_lat_reg <= b_lat_next;
			c_dir_reg <= c_dir_next;
			c_lat_reg <= c_lat_next;
			d_dir_reg <= d_dir_next;
			d_lat_reg <= d_lat_next;
			ctrl_reg  <= ctrl_next;
		end
	end

	// read data stand one cycle, then fall back to zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= `GPOP_RESET_VALUE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// port d override table
	// bits 7..4 never touch pull-up or direction
	always_comb begin
		d_pu_oe = 8'h00;
		d_pu_ov = 8'h00;
		d_dd_oe = 8'h00;
		d_dd_ov = 8'h00;
		d_pv_oe = 8'h00;
		d_pv_ov = 8'h00;
		d_die_oe = pin_change_mask_d & {8{pin_change_group2_enable}};
		// pd0: receiver makes it an input; pull-up stays with the latch
		d_pu_oe[0] = receiver_enable;
		d_pu_ov[0] = d_lat_reg[0] & ~pullup_off;
		d_dd_oe[0] = receiver_enable;
		d_dd_ov[0] = 1'b0;
		// pd1: transmitter owns pull-up, direction and value
		d_pu_oe[1] = transmitter_enable;
		d_pu_ov[1] = 1'b0;
		d_dd_oe[1] = transmitter_enable;
		d_dd_ov[1] = 1'b1;
		d_pv_oe[1] = transmitter_enable;
		d_pv_ov[1] = serial_tx_data;
		// group 2 used for port d; it owns pd0..pd7
		d_die_oe[2] = ext_irq_zero_enable | d_die_oe[2];
		d_die_oe[3] = ext_irq_one_enable | d_die_oe[3];
		d_pv_oe[3] = timer2_compare_b_enable;
		d_pv_ov[3] = timer2_compare_out_b;
		d_pv_oe[4] = serial_sync_mode_select;
		d_pv_ov[4] = serial_sync_clock_out;
		d_pv_oe[5] = timer0_compare_b_enable;
		d_pv_ov[5] = timer0_compare_out_b;
		d_pv_oe[6] = timer0_compare_a_enable;
		d_pv_ov[6] = timer0_compare_out_a;
	end

	// port b: plain pins, no alternate functions in this block
	generate
		for (genvar i = 0; i < PORT_W; i++) begin : g_b
			gpop_pin u_b (
				.dir_bit      (b_dir_reg[i]),
				.latch_bit    (b_lat_reg[i]),
				.pullup_off   (pullup_off),
				.pu_oe        (1'b0),
				.pu_ov        (1'b0),
				.dd_oe        (1'b0),
				.dd_ov        (1'b0),
				.pv_oe        (1'b0),
				.pv_ov        (1'b0),
				.die_oe       (1'b0),
				.die_ov       (1'b0),
				.pad_out      (pad_b_out[i]),
				.pad_oe       (pad_b_oe[i]),
				.pad_pullup   (pad_b_pullup[i]),
				.pad_input_en ()
			);
		end

		// port c: plain pins; bit 7 has no register bits
		for (genvar i = 0; i < PORT_W; i++) begin : g_c
			gpop_pin u_c (
				.dir_bit      (c_dir_reg[i]),
				.latch_bit    (c_lat_reg[i]),
				.pullup_off   (pullup_off),
				.pu_oe        (1'b0),
				.pu_ov        (1'b0),
				.dd_oe        (1'b0),
				.dd_ov        (1'b0),
				.pv_oe        (1'b0),
				.pv_ov        (1'b0),
				.die_oe       (1'b0),
				.die_ov       (1'b0),
				.pad_out      (pad_c_out[i]),
				.pad_oe       (pad_c_oe[i]),
				.pad_pullup   (pad_c_pullup[i]),
				.pad_input_en ()
			);
		end

		// port d: override table applied per pin
		for (genvar i = 0; i < PORT_W; i++) begin : g_d
			gpop_pin u_d (
				.dir_bit      (d_dir_reg[i]),
				.latch_bit    (d_lat_reg[i]),
				.pullup_off   (pullup_off),
				.pu_oe        (d_pu_oe[i]),
				.pu_ov        (d_pu_ov[i]),
				.dd_oe        (d_dd_oe[i]),
				.dd_ov        (d_dd_ov[i]),
				.pv_oe        (d_pv_oe[i]),
				.pv_ov        (d_pv_ov[i]),
				.die_oe       (d_die_oe[i]),
				.die_ov       (1'b1),
				.pad_out      (pad_d_out[i]),
				.pad_oe       (pad_d_oe[i]),
				.pad_pullup   (pad_d_pullup[i]),
				.pad_input_en (pad_d_input_en[i])
			);
		end
	endgenerate

	// peripheral inputs from synchronised pad levels
	// levels only; edges are found by the interrupt controller
	assign serial_rx_data       = d_s2_reg[0];
	assign ext_irq_zero         = d_s2_reg[2];
	assign ext_irq_one          = d_s2_reg[3];
	assign serial_sync_clock_in = d_s2_reg[4];
	assign timer0_count_input   = d_s2_reg[4];
	assign timer1_count_input   = d_s2_reg[5];
	assign pin_change_src_d     = d_s2_reg;
endmodule : gpop_port

// file: pkg/gpop_params.svh
// register offsets, field positions and reset values for the port block
// assumes a 6-bit register space reached through a plain strobe port
`ifndef GPOP_PARAMS_SVH
`define GPOP_PARAMS_SVH
`define GPOP_ADDR_W          6
`define GPOP_OFF_B_PIN       6'h03
`define GPOP_OFF_B_DIR       6'h04
`define GPOP_OFF_B_LAT       6'h05
`define GPOP_OFF_C_PIN       6'h06
`define GPOP_OFF_C_DIR       6'h07
`define GPOP_OFF_C_LAT       6'h08
`define GPOP_OFF_D_PIN       6'h09
`define GPOP_OFF_D_DIR       6'h0a
`define GPOP_OFF_D_LAT       6'h0b
`define GPOP_OFF_CTRL        6'h35
`define GPOP_CTRL_PUD_BIT    4
`define GPOP_CTRL_MASK       8'h73
`define GPOP_PORT_C_MASK     8'h7f
`define GPOP_RESET_VALUE     8'h00
`endif

// file: pkg/gpop_pkg.sv
// types shared by the port block files
// assumes gpop_params.svh holds all numeric constants
package gpop_pkg;
	typedef logic [7:0] gpop_byte_t;
endpackage : gpop_pkg

// file: rtl/gpop_pin.sv
// one pin: override muxing for pull-up, direction, output and input buffer
// assumes pad level is synchronised by the caller
`timescale 1ns/1ps
module gpop_pin (
	// register view
	input  wire logic dir_bit,
	input  wire logic latch_bit,
	input  wire logic pullup_off,
	// overrides
	input  wire logic pu_oe,
	input  wire logic pu_ov,
	input  wire logic dd_oe,
	input  wire logic dd_ov,
	input  wire logic pv_oe,
	input  wire logic pv_ov,
	input  wire logic die_oe,
	input  wire logic die_ov,
	// pad side
	output logic      pad_out,
	output logic      pad_oe,
	output logic      pad_pullup,
	output logic      pad_input_en
);
	logic dir_eff;
	always_comb begin
		dir_eff      = dd_oe ? dd_ov : dir_bit;
		pad_oe       = dir_eff;
		pad_out      = pv_oe ? pv_ov : latch_bit;
		pad_pullup   = pu_oe ? pu_ov : (~dir_bit & latch_bit & ~pullup_off);
		pad_input_en = die_oe ? die_ov : 1'b1;
	end
endmodule : gpop_pin

// file: dv/gpop_port_monitor.sv
// concurrent checks on the port block pads and register port
// assumes one clock domain and binding onto gpop_port
`timescale 1ns/1ps
`include "gpop_params.svh"
module gpop_port_monitor (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// register port
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	// pads
	input wire logic [7:0] pad_b_pullup,
	input wire logic [7:0] pad_d_in,
	input wire logic [7:0] pad_d_out,
	input wire logic [7:0] pad_d_oe,
	input wire logic [7:0] pad_d_pullup,
	input wire logic [7:0] pad_d_input_en,
	// peripherals
	input wire logic       transmitter_enable,
	input wire logic       receiver_enable,
	input wire logic       serial_tx_data,
	input wire logic       timer2_compare_b_enable,
	input wire logic       timer2_compare_out_b,
	input wire logic       serial_rx_data,
	input wire logic       serial_sync_clock_in,
	input wire logic       timer0_count_input,
	input wire logic [7:0] pin_change_src_d
);
	logic pulloff_reg;
	logic pulloff_next;
	// shadow of the global pull-up disable, tracked from bus writes
	always_comb begin
		pulloff_next = pulloff_reg;
		if (reg_write && reg_addr == `GPOP_OFF_CTRL)
			pulloff_next = reg_wdata[`GPOP_CTRL_PUD_BIT];
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pulloff_reg <= 1'b0;
		else
			pulloff_reg <= pulloff_next;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_tx_forces_out: assert property (transmitter_enable |-> pad_d_oe[1] && !pad_d_pullup[1]
		&& pad_d_out[1] == serial_tx_data) else $error("tx pin not forced");
	a_rx_forces_in: assert property (receiver_enable |-> !pad_d_oe[0])
		else $error("rx pin driven");
	a_pull_global_off: assert property (pulloff_reg |-> pad_b_pullup == 8'h00 && pad_d_pullup == 8'h00)
		else $error("pull-up on while disabled");
	a_pin_toggle: assert property (reg_write && reg_addr == `GPOP_OFF_D_PIN |=>
		{pad_d_out[2], pad_d_out[0]} == ($past({pad_d_out[2], pad_d_out[0]}) ^ $past({reg_wdata[2], reg_wdata[0]})))
		else $error("pin write did not toggle");
	a_t2_out: assert property (timer2_compare_b_enable |-> pad_d_out[3] == timer2_compare_out_b)
		else $error("pd3 compare output lost");
	a_rx_synced: assert property (!$past(rst) && !$past(rst, 2) |-> serial_rx_data == $past(pad_d_in[0], 2))
		else $error("rx data not two-stage synced");
	a_pd4_fanout: assert property (!$past(rst) && !$past(rst, 2) |->
		serial_sync_clock_in == $past(pad_d_in[4], 2) && timer0_count_input == $past(pad_d_in[4], 2)
		&& pin_change_src_d[4] == $past(pad_d_in[4], 2)) else $error("pd4 fanout differs");
	a_input_buf_on: assert property (pad_d_input_en == 8'hff)
		else $error("input buffer off");
	c_tx: cover property (transmitter_enable && serial_tx_data);
	c_rx_pull: cover property (receiver_enable && pad_d_pullup[0]);
	c_pulloff: cover property (pulloff_reg);
endmodule : gpop_port_monitor
bind gpop_port gpop_port_monitor u_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .pad_b_pullup(pad_b_pullup), .pad_d_in(pad_d_in), .pad_d_out(pad_d_out),
	.pad_d_oe(pad_d_oe), .pad_d_pullup(pad_d_pullup), .pad_d_input_en(pad_d_input_en),
	.transmitter_enable(transmitter_enable), .receiver_enable(receiver_enable), .serial_tx_data(serial_tx_data),
	.timer2_compare_b_enable(timer2_compare_b_enable), .timer2_compare_out_b(timer2_compare_out_b),
	.serial_rx_data(serial_rx_data), .serial_sync_clock_in(serial_sync_clock_in),
	.timer0_count_input(timer0_count_input), .pin_change_src_d(pin_change_src_d));

// file: dv/gpop_pad_model.sv
// external circuit on one 8-pin port: driver, pull-up and floating pins
// assumes the bench commands the external driver levels
`timescale 1ns/1ps
module gpop_pad_model (
	// clock
	input wire logic       clk,
	// device side
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pullup,
	// external driver
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_lvl,
	// level seen by the device
	output logic     [7:0] pad_in
);
	logic [7:0] float_reg = 8'h55;
	// a floating pin wanders, so nothing may rely on it
	always_ff @(posedge clk) float_reg <= ~float_reg;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_lvl[i];
			else
				pad_in[i] = pad_pullup[i] | float_reg[i];
		end
	end
endmodule : gpop_pad_model

// file: dv/tb_gpio_port_override_regs.sv
// bench for the port block: registers, overrides and pad sensing
// assumes a pad model on each port and the checker bound to dut
`timescale 1ns/1ps
module tb_gpio_port_override_regs;
	logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wd = 8'h00, rdat, eb = 8'h00, ec = 8'h00, ed = 8'h00, mask = 8'h00;
	logic [7:0] bi, ci, di, bo, be, bp, co, ce, cp, dout, doe, dpu, die, pcs;
	logic tx_en = 1'b0, rx_en = 1'b0, tx_d = 1'b0, ssel = 1'b0, sco = 1'b0, rxd, sci, t0c, t1c, i0, i1;
	logic t0a_en = 1'b0, t0a = 1'b0, t0b_en = 1'b0, t0b = 1'b0, t2_en = 1'b0, t2 = 1'b0;
	logic i0_en = 1'b0, i1_en = 1'b0, g2 = 1'b0;
	logic [5:0] ra [8] = '{6'h04, 6'h05, 6'h07, 6'h08, 6'h0a, 6'h0b, 6'h35, 6'h20};
	int fail_count = 0, n_compared = 0;
	initial forever #4 clk = ~clk;
	gpop_port dut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd), .reg_write(wr_s), .reg_read(rd_s),
		.reg_rdata(rdat), .pad_b_in(bi), .pad_c_in(ci), .pad_d_in(di), .pad_b_out(bo), .pad_b_oe(be),
		.pad_b_pullup(bp), .pad_c_out(co), .pad_c_oe(ce), .pad_c_pullup(cp), .pad_d_out(dout), .pad_d_oe(doe),
		.pad_d_pullup(dpu), .pad_d_input_en(die), .transmitter_enable(tx_en), .receiver_enable(rx_en),
		.serial_tx_data(tx_d), .serial_sync_mode_select(ssel), .serial_sync_clock_out(sco), .serial_rx_data(rxd),
		.serial_sync_clock_in(sci), .timer0_compare_a_enable(t0a_en), .timer0_compare_out_a(t0a),
		.timer0_compare_b_enable(t0b_en), .timer0_compare_out_b(t0b), .timer2_compare_b_enable(t2_en),
		.timer2_compare_out_b(t2), .timer0_count_input(t0c), .timer1_count_input(t1c), .ext_irq_zero_enable(i0_en),
		.ext_irq_one_enable(i1_en), .pin_change_mask_d(mask), .pin_change_group2_enable(g2), .ext_irq_zero(i0),
		.ext_irq_one(i1), .pin_change_src_d(pcs));
	gpop_pad_model pm_b (.clk(clk), .pad_out(bo), .pad_oe(be), .pad_pullup(bp), .ext_en(8'hff), .ext_lvl(eb), .pad_in(bi));
	gpop_pad_model pm_c (.clk(clk), .pad_out(co), .pad_oe(ce), .pad_pullup(cp), .ext_en(8'hff), .ext_lvl(ec), .pad_in(ci));
	gpop_pad_model pm_d (.clk(clk), .pad_out(dout), .pad_oe(doe), .pad_pullup(dpu), .ext_en(8'hff), .ext_lvl(ed),
		.pad_in(di));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk(rdat, exp);
	endtask : rd
	// three edges cover the two-stage input synchroniser
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (ra[i]) rd(ra[i], 8'h00);
		wr(6'h04, 8'hff);
		wr(6'h05, 8'ha5);
		settle;
		rd(6'h03, 8'ha5);
		chk(bo, 8'ha5);
		chk(be, 8'hff);
		wr(6'h07, 8'hff);
		rd(6'h07, 8'h7f);
		wr(6'h08, 8'hff);
		wr(6'h06, 8'h8f);
		ec <= 8'h80;
		settle;
		chk(co, 8'h70);
		chk(ce, 8'h7f);
		rd(6'h06, 8'h70);
		rd(6'h08, 8'h70);
		wr(6'h35, 8'hff);
		rd(6'h35, 8'h73);
		wr(6'h04, 8'h00);
		wr(6'h05, 8'hff);
		eb <= 8'h3c;
		settle;
		chk(bp, 8'h00);
		rd(6'h03, 8'h3c);
		wr(6'h35, 8'h00);
		settle;
		chk(bp, 8'hff);
		wr(6'h0b, 8'h0f);
		wr(6'h09, 8'h3c);
		rd(6'h0b, 8'h33);
		wr(6'h0a, 8'h00);
		tx_en <= 1'b1;
		tx_d <= 1'b1;
		settle;
		chk({5'h00, doe[1], dout[1], dpu[1]}, 8'h06);
		@(posedge clk);
		tx_en <= 1'b0;
		rx_en <= 1'b1;
		wr(6'h0a, 8'hff);
		settle;
		chk({6'h00, doe[0], dpu[0]}, 8'h01);
		chk({7'h00, rxd}, 8'h00);
		wr(6'h35, 8'h10);
		ed <= 8'h01;
		settle;
		chk({6'h00, dpu[0], rxd}, 8'h01);
		wr(6'h35, 8'h00);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk);
			{t0a_en, t0b_en, t2_en, ssel} <= 4'hf;
			{t0a, t0b, sco, t2} <= {4{v[0]}};
			settle;
			chk({4'h0, dout[6:3]}, {4'h0, {4{v[0]}}});
		end
		@(posedge clk);
		{t0a_en, t0b_en, t2_en, ssel, rx_en} <= 5'h00;
		wr(6'h0a, 8'h00);
		ed <= 8'h14;
		settle;
		chk(pcs, 8'h14);
		chk({3'h0, t0c, sci, t1c, i0, i1}, 8'h1a);
		@(posedge clk);
		{i0_en, i1_en, g2} <= 3'h7;
		mask <= 8'hff;
		settle;
		chk(die, 8'hff);
		conclude;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		conclude;
	end
endmodule : tb_gpio_port_override_regs
